// [tabc_regs.vh]
`ifndef TABC_REGS_VH
`define TABC_REGS_VH

// register byte offsets
`define TABC_OFF_AXI_CTRL 12'h110
`define TABC_OFF_BUF_LO 12'h114
`define TABC_OFF_BUF_HI 12'h118
`define TABC_OFF_FLUSH_STS 12'h11c

// axi_master_control field positions
`define TABC_BEATS_MSB 11
`define TABC_BEATS_LSB 8
`define TABC_LAYOUT_BIT 7
`define TABC_WALLOC_BIT 5
`define TABC_RALLOC_BIT 4
`define TABC_CACHEABLE_BIT 3
`define TABC_BUFFERABLE_BIT 2
`define TABC_NONSECURE_BIT 1
`define TABC_PRIVILEGED_BIT 0

// formatter_flush_status field positions
`define TABC_HALTED_BIT 1
`define TABC_FLUSH_BIT 0

// reset values and masks
`define TABC_AXI_CTRL_RST 32'h0000_0000
`define TABC_BUF_LO_RST 32'h0000_0000
`define TABC_BUF_HI_RST 8'h00
`define TABC_BEATS_RST 5'h01
`define TABC_AXI_CTRL_MASK 32'h0000_0fbf
`define TABC_WBUF_DEPTH 16

`endif

// [tabc_burst_limit.v]
`timescale 1ns/1ps
// -------------------------------------------------------------
// write burst length limiter
// -------------------------------------------------------------
module tabc_burst_limit #(
   parameter WBUF_DEPTH = 16
) (
   input wire [3:0] beats_field,
   input wire formatter_halted,
   input wire [4:0] words_pending,
   output reg [4:0] burst_beats
);
   reg [4:0] programmed;
   always @* begin
      programmed = {1'b0, beats_field} + 5'h01; // R4
      burst_beats = programmed;
      if (programmed > WBUF_DEPTH[4:0]) begin
         burst_beats = WBUF_DEPTH[4:0]; // R6
      end
      // only a stopped formatter may leave a short tail burst
      if (formatter_halted && (words_pending < burst_beats) && (words_pending != 5'h00)) begin
         burst_beats = words_pending; // R5
      end
   end
endmodule // tabc_burst_limit

// [tabc_axi_buffer_ctrl.v]
// Function
// R1 - protection bit 2 always low: data access
// R2 - software writes control only while disabled
// R3 - software typically sets attribute bits to ones
// R4 - burst beats equal field value plus one
// R5 - shorter burst allowed after formatter stop
// R6 - burst capped at write buffer depth
// R7 - software keeps burst bytes within buffer
// R8 - software keeps burst at half buffer
// R9 - bit 7 selects linked-list layout, ignored disabled; the buffer address split still follows bit 7 while disabled
// R10 - bit 5 drives cache bit 3
// R11 - bit 4 drives cache bit 2
// R12 - software keeps allocate bits low uncached
// R13 - bit 3 drives cache bit 1
// R14 - bit 2 drives cache bit 0
// R15 - bit 1 drives protection bit 1
// R16 - bit 0 drives protection bit 0
// R17 - low register gives address bits 31:0
// R18 - high register gives address bits 39:32
// R19 - address is base or first table entry
// R20 - software changes address only while disabled
// R21 - status bit 1 mirrors formatter drained
// R22 - status bit 0 mirrors flush valid
// R23 - flush started by control or downstream
// R24 - 32-bit registers, reserved zero, status read-only
`timescale 1ns/1ps
`include "tabc_regs.vh"
module tabc_axi_buffer_ctrl #(
   parameter WBUF_DEPTH = `TABC_WBUF_DEPTH,
   parameter FORWARDING_CFG = 0
) (
   input wire clock,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire controller_disabled,
   input wire formatter_drained_flag,
   input wire input_flush_valid_out,
   input wire formatter_halted_flag,
   input wire [4:0] words_pending,
   input wire manual_flush_req,
   input wire downstream_flush_req,
   output reg [3:0] read_cache_attr_out,
   output reg [3:0] write_cache_attr_out,
   output reg [2:0] read_protection_out,
   output reg [2:0] write_protection_out,
   output reg [4:0] write_burst_beats,
   output reg linked_list_layout,
   output reg [39:0] trace_base_addr,
   output reg [39:0] page_table_addr,
   output reg flush_start
);
   // -------------------------------------------------------------
   // register storage
   // -------------------------------------------------------------
   reg [31:0] axi_ctrl_ff;
   reg [31:0] buf_lo_ff;
   reg [7:0] buf_hi_ff;
   reg [31:0] nxt_axi_ctrl;
   reg [31:0] nxt_buf_lo;
   reg [7:0] nxt_buf_hi;
   reg [31:0] nxt_prdata;
   reg nxt_pslverr;
   reg [3:0] nxt_cache_attr;
   reg [2:0] nxt_prot_attr;
   reg nxt_layout;
   reg [39:0] nxt_trace_base;
   reg [39:0] nxt_page_table;
   reg nxt_flush_start;
   wire setup_phase;
   wire rd_setup;
   wire wr_access;
   wire ctrl_wr;
   wire lo_wr;
   wire hi_wr;
   wire fwd_enabled;
   wire [4:0] nxt_beats;
   wire [39:0] buf_addr;

   // -------------------------------------------------------------
   // access decode
   // -------------------------------------------------------------
   assign setup_phase = psel & ~penable;
   assign rd_setup = setup_phase & ~pwrite;
   // writes land in the access phase; the enable is never checked against
   // controller state, so an early write simply takes effect at once
   assign wr_access = psel & penable & pwrite & pready;
   assign ctrl_wr = wr_access & (paddr == `TABC_OFF_AXI_CTRL);
   assign lo_wr = wr_access & (paddr == `TABC_OFF_BUF_LO);
   assign hi_wr = wr_access & (paddr == `TABC_OFF_BUF_HI);
   assign fwd_enabled = (FORWARDING_CFG != 0);
   assign buf_addr = {buf_hi_ff, buf_lo_ff}; // R17 R18

   // -------------------------------------------------------------
   // register next values
   // -------------------------------------------------------------
   // reserved bits are masked on the way in, so reads need no mask
   always @* begin
      nxt_axi_ctrl = axi_ctrl_ff;
      nxt_buf_lo = buf_lo_ff;
      nxt_buf_hi = buf_hi_ff;
      if (ctrl_wr) begin
         nxt_axi_ctrl = pwdata & `TABC_AXI_CTRL_MASK; // R24
      end
      if (lo_wr) begin
         nxt_buf_lo = pwdata; // R17
      end
      if (hi_wr) begin
         nxt_buf_hi = pwdata[7:0]; // R18
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         axi_ctrl_ff <= `TABC_AXI_CTRL_RST;
      end else begin
         axi_ctrl_ff <= nxt_axi_ctrl;
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         buf_lo_ff <= `TABC_BUF_LO_RST;
      end else begin
         buf_lo_ff <= nxt_buf_lo;
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         buf_hi_ff <= `TABC_BUF_HI_RST;
      end else begin
         buf_hi_ff <= nxt_buf_hi;
      end
   end

   // -------------------------------------------------------------
   // read mux, sampled in the setup phase
   // -------------------------------------------------------------
   always @* begin
      nxt_prdata = 32'h0000_0000;
      nxt_pslverr = 1'b0;
      case (paddr)
         `TABC_OFF_AXI_CTRL: nxt_prdata = axi_ctrl_ff;
         `TABC_OFF_BUF_LO: nxt_prdata = buf_lo_ff;
         `TABC_OFF_BUF_HI: nxt_prdata = {24'h000000, buf_hi_ff}; // R24
         `TABC_OFF_FLUSH_STS: begin
            nxt_prdata[`TABC_HALTED_BIT] = formatter_drained_flag; // R21
            nxt_prdata[`TABC_FLUSH_BIT] = input_flush_valid_out; // R22
            nxt_pslverr = pwrite; // R24
         end
         default: nxt_pslverr = 1'b1;
      endcase
   end

   // -------------------------------------------------------------
   // bus response
   // -------------------------------------------------------------
   // one wait-free access: pready rises for the access phase only
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
      end else begin
         pready <= setup_phase;
      end
   end

   // the error flag stands only beside pready, never on its own
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         pslverr <= 1'b0;
      end else begin
         pslverr <= setup_phase & nxt_pslverr; // R24
      end
   end

   // read data is caught in the setup phase and then held, so it stays
   // steady through the access phase whatever the address does next
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= nxt_prdata;
      end
   end

   // -------------------------------------------------------------
   // axi attribute and address outputs
   // -------------------------------------------------------------
   tabc_burst_limit #(
      .WBUF_DEPTH(WBUF_DEPTH)
   ) u_limit (
      .beats_field(axi_ctrl_ff[`TABC_BEATS_MSB:`TABC_BEATS_LSB]),
      .formatter_halted(formatter_halted_flag),
      .words_pending(words_pending),
      .burst_beats(nxt_beats)
   );

   // -------------------------------------------------------------
   // attribute next values
   // -------------------------------------------------------------
   // both channels carry the same attributes, so one next value feeds both
   always @* begin
      nxt_cache_attr = {axi_ctrl_ff[`TABC_WALLOC_BIT], // R10
         axi_ctrl_ff[`TABC_RALLOC_BIT], // R11
         axi_ctrl_ff[`TABC_CACHEABLE_BIT], // R13
         axi_ctrl_ff[`TABC_BUFFERABLE_BIT]}; // R14
      nxt_prot_attr = {1'b0, // R1
         axi_ctrl_ff[`TABC_NONSECURE_BIT], // R15
         axi_ctrl_ff[`TABC_PRIVILEGED_BIT]}; // R16
      // layout means nothing while disabled, so it is held low then
      nxt_layout = axi_ctrl_ff[`TABC_LAYOUT_BIT] & ~controller_disabled; // R9
      // only one of the two address outputs carries the buffer address
      nxt_trace_base = 40'h00_0000_0000;
      nxt_page_table = 40'h00_0000_0000;
      if (axi_ctrl_ff[`TABC_LAYOUT_BIT]) begin
         nxt_page_table = buf_addr; // R19
      end else begin
         nxt_trace_base = buf_addr; // R19
      end
      nxt_flush_start = manual_flush_req | (fwd_enabled & downstream_flush_req); // R23
   end

   // -------------------------------------------------------------
   // axi attribute registers
   // -------------------------------------------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         read_cache_attr_out <= 4'h0;
      end else begin
         read_cache_attr_out <= nxt_cache_attr; // R10 R11 R13 R14
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         write_cache_attr_out <= 4'h0;
      end else begin
         write_cache_attr_out <= nxt_cache_attr; // R10 R11 R13 R14
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         read_protection_out <= 3'h0;
      end else begin
         read_protection_out <= nxt_prot_attr; // R1 R15 R16
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         write_protection_out <= 3'h0;
      end else begin
         write_protection_out <= nxt_prot_attr; // R1 R15 R16
      end
   end

   // registered so the burst engine always sees a settled count
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         write_burst_beats <= `TABC_BEATS_RST;
      end else begin
         write_burst_beats <= nxt_beats; // R4 R5 R6
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         linked_list_layout <= 1'b0;
      end else begin
         linked_list_layout <= nxt_layout; // R9
      end
   end

   // -------------------------------------------------------------
   // buffer address and flush registers
   // -------------------------------------------------------------
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         trace_base_addr <= 40'h00_0000_0000;
      end else begin
         trace_base_addr <= nxt_trace_base; // R19
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         page_table_addr <= 40'h00_0000_0000;
      end else begin
         page_table_addr <= nxt_page_table; // R19
      end
   end

   always @(posedge clock or posedge reset) begin
      if (reset) begin
         flush_start <= 1'b0;
      end else begin
         flush_start <= nxt_flush_start; // R23
      end
   end
endmodule // tabc_axi_buffer_ctrl

// [tabc_sysmem_model.sv]
`timescale 1ns/1ps
// ---
// system memory side
// ---
module tabc_sysmem_model (
   input wire [3:0] cache_attr,
   input wire [2:0] prot_attr,
   output wire attr_legal
);
   // memory takes data accesses only, allocate hints only when cacheable
   assign attr_legal = !prot_attr[2] && (cache_attr[1] || cache_attr[3:2] == 2'b00);
endmodule // tabc_sysmem_model

// [tabc_monitor.sv]
`timescale 1ns/1ps
// ---
// bus and attribute checks
// ---
module tabc_monitor (
   input wire clock,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire pready,
   input wire pslverr,
   input wire controller_disabled,
   input wire formatter_drained_flag,
   input wire input_flush_valid_out,
   input wire manual_flush_req,
   input wire linked_list_layout,
   input wire flush_start,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   input wire [2:0] read_protection_out,
   input wire [2:0] write_protection_out,
   input wire [4:0] write_burst_beats,
   input wire [39:0] trace_base_addr
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_sts;
      s_setup ##0 paddr == 12'h11c;
   endsequence
   sequence s_access_end;
      pready ##1 !pready;
   endsequence
   a_ready_once: assert property (s_setup |=> s_access_end) else $error("ready");
   a_err_ready: assert property (pslverr |-> pready) else $error("err alone");
   a_prot_data: assert property (!read_protection_out[2] && !write_protection_out[2])
      else $error("prot");
   a_beats_range: assert property (write_burst_beats inside {[5'h01:5'h10]})
      else $error("beats");
   a_layout_off: assert property (controller_disabled |=> !linked_list_layout)
      else $error("layout");
   a_addr_split: assert property (linked_list_layout |-> trace_base_addr == 40'h0)
      else $error("addr");
   a_flush_follow: assert property (manual_flush_req |=> flush_start) else $error("flush");
   a_sts_read: assert property (s_sts ##0 !pwrite |=>
      prdata == {30'h0, $past(formatter_drained_flag), $past(input_flush_valid_out)})
      else $error("sts");
   a_sts_rd_ok: assert property (s_sts ##0 !pwrite |=> !pslverr) else $error("sts err");
   a_sts_refuse: assert property (s_sts ##0 pwrite |=> pslverr) else $error("ro");
endmodule // tabc_monitor
bind tabc_axi_buffer_ctrl tabc_monitor i_tabc_monitor (.*);

// [test_trace_axi_buffer_control.sv]
`timescale 1ns/1ps
// ---
// register bank bench
// ---
module test_trace_axi_buffer_control;
   reg clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, e;
   reg controller_disabled = 1, formatter_drained_flag = 0, input_flush_valid_out = 0;
   reg formatter_halted_flag = 0, manual_flush_req = 0, downstream_flush_req = 0;
   reg [11:0] paddr = 0;
   reg [31:0] pwdata = 0, rd, c, lo, hi;
   reg [4:0] words_pending = 0;
   wire [31:0] prdata;
   wire pready, pslverr, linked_list_layout, flush_start, legal, fwd_flush_start;
   wire [3:0] read_cache_attr_out, write_cache_attr_out;
   wire [2:0] read_protection_out, write_protection_out;
   wire [4:0] write_burst_beats;
   wire [39:0] trace_base_addr, page_table_addr;
   integer miscompares = 0, n_checks = 0, cyc = 0, i;
   // depth 8 so the cap is reachable from the 4-bit field
   tabc_axi_buffer_ctrl #(.WBUF_DEPTH(8)) i_tabc_axi_buffer_ctrl (.*);
   tabc_sysmem_model i_tabc_sysmem_model (.cache_attr(write_cache_attr_out),
      .prot_attr(write_protection_out), .attr_legal(legal));
   // second copy with downstream flush requests honoured
   tabc_axi_buffer_ctrl #(.WBUF_DEPTH(8), .FORWARDING_CFG(1)) i_tabc_axi_buffer_ctrl_fwd (
      .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
      .controller_disabled(controller_disabled),
      .formatter_drained_flag(formatter_drained_flag),
      .input_flush_valid_out(input_flush_valid_out),
      .formatter_halted_flag(formatter_halted_flag), .words_pending(words_pending),
      .manual_flush_req(manual_flush_req), .downstream_flush_req(downstream_flush_req),
      .read_cache_attr_out(), .write_cache_attr_out(), .read_protection_out(),
      .write_protection_out(), .write_burst_beats(), .linked_list_layout(),
      .trace_base_addr(), .page_table_addr(), .flush_start(fwd_flush_start));
   initial forever #2.5 clock = ~clock;
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 4000) begin
         miscompares = miscompares + 1;
         conclude;
      end
   end
   task chk(input string nm, input [39:0] seen, input [39:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // entered at a falling edge; read data taken at the access edge
   task apb(input w, input [11:0] a, input [31:0] d);
      {psel, pwrite, paddr, pwdata} = {1'b1, w, a, d};
      @(negedge clock) penable = 1;
      @(posedge clock) {e, rd} = {pslverr, prdata};
      chk("ready", pready, 1);
      @(negedge clock) {psel, penable} = 2'b00;
      // a spare cycle, so select is never driven twice in one step
      @(negedge clock);
   endtask
   function [4:0] beats(input [3:0] f, input h, input [4:0] p);
      beats = (f > 4'h7) ? 5'h08 : {1'b0, f} + 5'h01;
      if (h && p != 5'h00 && p < beats) beats = p;
   endfunction
   initial begin
      void'($urandom(32'h6bde8e57));
      repeat (4) @(negedge clock);
      reset = 0;
      apb(0, 12'h110, 0);
      chk("rst", {rd, write_burst_beats}, 1);
      for (i = 0; i < 16; i = i + 1) begin
         c = ($urandom & 32'hffff_f0ff) | (i << 8);
         if (!c[3]) c[5:4] = 2'b00;
         if (i == 3) c[5:0] = 6'h3f;
         {lo, hi} = {$urandom, $urandom};
         controller_disabled = 1;
         apb(1, 12'h110, c);
         apb(1, 12'h114, lo);
         apb(1, 12'h118, hi);
         {controller_disabled, formatter_halted_flag, words_pending} = $urandom;
         apb(0, 12'h110, 0);
         chk("ctrl", rd, c & 32'hfbf);
         chk("ctrl err", e, 0);
         apb(0, 12'h118, 0);
         chk("high", rd, hi & 32'hff);
         chk("cache", read_cache_attr_out, c[5:2]);
         chk("wcache", write_cache_attr_out, c[5:2]);
         chk("prot", write_protection_out, {1'b0, c[1:0]});
         chk("rprot", read_protection_out, {1'b0, c[1:0]});
         chk("beats", write_burst_beats, beats(c[11:8], formatter_halted_flag, words_pending));
         chk("layout", linked_list_layout, c[7] & ~controller_disabled);
         chk("addr", c[7] ? page_table_addr : trace_base_addr, {hi[7:0], lo});
         chk("spare addr", c[7] ? trace_base_addr : page_table_addr, 0);
         chk("legal", legal, 1);
      end
      for (i = 0; i < 4; i = i + 1) begin
         {formatter_drained_flag, input_flush_valid_out} = i;
         apb(0, 12'h11c, 0);
         chk("status", rd, i);
      end
      apb(1, 12'h11c, 32'h3);
      chk("ro", e, 1);
      apb(0, 12'h124, 0);
      chk("unmapped", {e, rd}, 33'h1_0000_0000);
      downstream_flush_req = 1;
      @(negedge clock) chk("fwd", flush_start, 0);
      chk("fwd on", fwd_flush_start, 1);
      manual_flush_req = 1;
      @(negedge clock) chk("flush", flush_start, 1);
      conclude;
   end
endmodule // test_trace_axi_buffer_control
